// ---- rtl/srsr_pkg.sv ----
// Constants, command codes and states for the status reporting block
package srsr_pkg;
    localparam int FLT_W = 16;
    localparam int STB_W = 8;
    // Fault group bit positions
    localparam int FLT_HV_BIT = 0;
    localparam int FLT_OC_BIT = 1;
    localparam int FLT_MAINS_BIT = 3;
    localparam int FLT_THERM_BIT = 4;
    localparam int FLT_TSHORT_BIT = 5;
    localparam int FLT_TTHRESH_BIT = 6;
    localparam int FLT_VCEIL_BIT = 8;
    localparam int FLT_CCEIL_BIT = 9;
    localparam int FLT_SHUT_BIT = 11;
    localparam int FLT_PCEIL_BIT = 12;
    localparam int FLT_SENSE_BIT = 13;
    localparam logic [15:0] FLT_USED = 16'h3B7B;
    // Status byte bit positions
    localparam int STB_FAULT_BIT = 3;
    localparam int STB_MSS_BIT = 6;
    // Reset values
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [15:0] RISE_RST = 16'h3B7B;
    localparam logic [15:0] FALL_RST = 16'h0000;
    localparam logic [15:0] ENA_RST = 16'h0000;
    // Trigger ignored, -211 in two's complement
    localparam logic [15:0] ERR_TRG_IGNORED = 16'hFF2D;
    localparam int SELF_TEST_CYCLES = 16;
    typedef enum logic [3:0] {
        CMD_SRE_SET = 4'h0, CMD_SRE_GET = 4'h1, CMD_STB_GET = 4'h2,
        CMD_TRG = 4'h3, CMD_TST = 4'h4, CMD_WAI = 4'h5,
        CMD_COND_GET = 4'h6, CMD_RISE_SET = 4'h7, CMD_RISE_GET = 4'h8,
        CMD_FALL_SET = 4'h9, CMD_FALL_GET = 4'hA, CMD_EVT_GET = 4'hB,
        CMD_ENA_SET = 4'hC, CMD_ENA_GET = 4'hD
    } srsr_cmd_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TEST = 3'b010,
        ST_WAIT = 3'b100
    } srsr_state_type;
endpackage : srsr_pkg

// ---- rtl/srsr_edge_latch.sv ----
// Transition filter and sticky event latch for one status group
`timescale 1ns/10ps
module srsr_edge_latch #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] cond,
    input wire logic [W-1:0] rise,
    input wire logic [W-1:0] fall,
    input wire logic clear,
    output logic [W-1:0] event_bits,
    output logic [W-1:0] set_bits
);
    logic [W-1:0] cond_prev;

    assign set_bits = (cond & ~cond_prev & rise) | (~cond & cond_prev & fall);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cond_prev <= '0;
        end else begin
            cond_prev <= cond;
        end
    end

    // New edges survive a clearing read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            event_bits <= '0;
        end else begin
            event_bits <= (clear ? '0 : event_bits) | set_bits;
        end
    end

    a_event_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (!clear && event_bits != '0) |=> ((event_bits & $past(event_bits)) == $past(event_bits)))
        else $error("Event bit dropped without a read");
endmodule : srsr_edge_latch

// ---- rtl/srsr_self_test.sv ----
// Self test sequencer returning a numeric fault code
`timescale 1ns/10ps
module srsr_self_test #(
    parameter int CYCLES = srsr_pkg::SELF_TEST_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [15:0] fault_code,
    output logic busy,
    output logic done,
    output logic [15:0] result
);
    logic [15:0] count;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            count <= 16'h0000;
            result <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                count <= 16'(CYCLES - 1);
            end else if (busy && count == 16'h0000) begin
                // Zero code means the checks found nothing
                busy <= 1'b0;
                done <= 1'b1;
                result <= fault_code;
            end else if (busy) begin
                count <= count - 16'h0001;
            end
        end
    end

    a_test_length: assert property (@(posedge clk) disable iff (sys_rst)
        (start && !busy) |=> busy [*2])
        else $error("Self test ended too early");
endmodule : srsr_self_test

// ---- rtl/srsr_top.sv ----
// Fault status group, status byte and service request with common commands
`timescale 1ns/10ps
module srsr_top
    import srsr_pkg::*;
#(
    parameter int TEST_CYCLES = srsr_pkg::SELF_TEST_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire srsr_pkg::srsr_cmd_type cmd_code,
    input wire logic [15:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic err_valid,
    output logic [15:0] err_code,
    input wire logic high_voltage_trip,
    input wire logic excess_current_trip,
    input wire logic mains_switch_off,
    input wire logic thermal_trip,
    input wire logic thermocouple_short,
    input wire logic temperature_threshold,
    input wire logic voltage_ceiling_hit,
    input wire logic current_ceiling_hit,
    input wire logic shutdown_alarm,
    input wire logic power_ceiling_hit,
    input wire logic sense_alarm,
    input wire logic [7:0] stb_external,
    input wire logic trig_accept_ok,
    input wire logic ops_busy,
    input wire logic [15:0] self_test_fault,
    output logic trig_pulse,
    output logic service_request,
    output logic [7:0] status_byte,
    output logic fault_summary
);
    import srsr_pkg::*;

    logic take;
    logic [15:0] fault_condition;
    logic [15:0] next_condition;
    logic [15:0] fault_rise_filter;
    logic [15:0] fault_fall_filter;
    logic [15:0] fault_enable_mask;
    logic [15:0] fault_event_latch;
    logic [15:0] evt_set;
    logic [7:0] service_request_mask;
    logic [7:0] next_stb;
    logic next_summary;
    logic next_mss;
    logic evt_clear;
    logic test_start;
    logic test_busy;
    logic test_done;
    logic [15:0] test_result;
    srsr_state_type state;
    srsr_state_type next_state;

    assign take = cmd_valid && cmd_ready;
    assign evt_clear = take && cmd_code == CMD_EVT_GET;
    assign test_start = take && cmd_code == CMD_TST;

    // Live condition assembly; unused bits stay zero
    always_comb begin
        next_condition = 16'h0000;
        next_condition[FLT_HV_BIT] = high_voltage_trip;
        next_condition[FLT_OC_BIT] = excess_current_trip;
        next_condition[FLT_THERM_BIT] = thermal_trip;
        next_condition[FLT_VCEIL_BIT] = voltage_ceiling_hit;
        next_condition[FLT_CCEIL_BIT] = current_ceiling_hit;
        next_condition[FLT_PCEIL_BIT] = power_ceiling_hit;
        next_condition[FLT_MAINS_BIT] = mains_switch_off;
        next_condition[FLT_TSHORT_BIT] = thermocouple_short;
        next_condition[FLT_TTHRESH_BIT] = temperature_threshold;
        next_condition[FLT_SHUT_BIT] = shutdown_alarm;
        next_condition[FLT_SENSE_BIT] = sense_alarm;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_condition <= 16'h0000;
        end else begin
            fault_condition <= next_condition;
        end
    end

    // Host-written masks
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            service_request_mask <= SRE_RST;
            fault_rise_filter <= RISE_RST;
            fault_fall_filter <= FALL_RST;
            fault_enable_mask <= ENA_RST;
        end else if (take) begin
            case (cmd_code)
                CMD_SRE_SET: service_request_mask <= cmd_data[7:0];
                CMD_RISE_SET: fault_rise_filter <= cmd_data;
                CMD_FALL_SET: fault_fall_filter <= cmd_data;
                CMD_ENA_SET: fault_enable_mask <= cmd_data;
                default: begin
                end
            endcase
        end
    end

    srsr_edge_latch #(
        .W(FLT_W)
    ) u_latch (
        .clk(clk),
        .sys_rst(sys_rst),
        .cond(fault_condition),
        .rise(fault_rise_filter),
        .fall(fault_fall_filter),
        .clear(evt_clear),
        .event_bits(fault_event_latch),
        .set_bits(evt_set)
    );

    srsr_self_test #(
        .CYCLES(TEST_CYCLES)
    ) u_test (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(test_start),
        .fault_code(self_test_fault),
        .busy(test_busy),
        .done(test_done),
        .result(test_result)
    );

    // Summary and request tree; bit 6 never feeds itself
    always_comb begin
        next_summary = |(fault_event_latch & fault_enable_mask);
        next_stb = stb_external;
        next_stb[STB_FAULT_BIT] = next_summary;
        next_stb[STB_MSS_BIT] = 1'b0;
        next_mss = |(next_stb & service_request_mask);
        next_stb[STB_MSS_BIT] = next_mss;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_summary <= 1'b0;
            status_byte <= 8'h00;
            service_request <= 1'b0;
        end else begin
            fault_summary <= next_summary;
            status_byte <= next_stb;
            service_request <= next_mss;
        end
    end

    // Command sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (test_start) begin
                    next_state = ST_TEST;
                end else if (take && cmd_code == CMD_WAI) begin
                    next_state = ST_WAIT;
                end
            end
            ST_TEST: begin
                if (test_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WAIT: begin
                // Held until the rest of the device reports idle
                if (!ops_busy && !test_busy) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            cmd_ready <= 1'b0;
        end else begin
            state <= next_state;
            cmd_ready <= next_state == ST_IDLE;
        end
    end

    // Query answers, one cycle after the command is taken; the self test code one cycle after test_done
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
        end else begin
            rsp_valid <= 1'b0;
            if (test_done) begin
                rsp_valid <= 1'b1;
                rsp_data <= test_result;
            end else if (take) begin
                rsp_valid <= 1'b1;
                case (cmd_code)
                    CMD_SRE_GET: rsp_data <= {8'h00, service_request_mask};
                    CMD_STB_GET: rsp_data <= {8'h00, next_stb};
                    CMD_COND_GET: rsp_data <= fault_condition;
                    CMD_RISE_GET: rsp_data <= fault_rise_filter;
                    CMD_FALL_GET: rsp_data <= fault_fall_filter;
                    CMD_ENA_GET: rsp_data <= fault_enable_mask;
                    CMD_EVT_GET: rsp_data <= fault_event_latch;
                    default: rsp_valid <= 1'b0;
                endcase
            end
        end
    end

    // Trigger or refusal
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            trig_pulse <= 1'b0;
            err_valid <= 1'b0;
            err_code <= 16'h0000;
        end else begin
            trig_pulse <= 1'b0;
            err_valid <= 1'b0;
            if (take && cmd_code == CMD_TRG) begin
                if (trig_accept_ok) begin
                    trig_pulse <= 1'b1;
                end else begin
                    err_valid <= 1'b1;
                    err_code <= ERR_TRG_IGNORED;
                end
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_wai_taken;
        take && cmd_code == CMD_WAI;
    endsequence

    sequence s_tst_taken;
        take && cmd_code == CMD_TST;
    endsequence

    a_sre_store: assert property (take && cmd_code == CMD_SRE_SET
        |=> service_request_mask == $past(cmd_data[7:0]))
        else $error("Request mask not stored");
    a_stb_mss_bit: assert property (take && cmd_code == CMD_STB_GET
        |=> rsp_valid && rsp_data[6] == $past(next_mss) && rsp_data[15:8] == 8'h00)
        else $error("Status byte answer lacks summary bit");
    a_trg_refused: assert property (take && cmd_code == CMD_TRG && !trig_accept_ok
        |=> err_valid && err_code == ERR_TRG_IGNORED && !trig_pulse)
        else $error("Refused trigger not reported");
    a_trg_fires: assert property (take && cmd_code == CMD_TRG && trig_accept_ok
        |=> trig_pulse && !err_valid ##1 (!trig_pulse || $past(take)))
        else $error("Trigger pulse missing");
    a_tst_answer: assert property (s_tst_taken |=> !cmd_ready ##[1:300] rsp_valid)
        else $error("Self test gave no answer");
    a_tst_code: assert property (test_done |=> rsp_valid && rsp_data == $past(test_result))
        else $error("Self test code wrong");
    a_wai_stall: assert property (s_wai_taken ##1 (ops_busy [*2]) |=> !cmd_ready)
        else $error("Command accepted during wait");
    a_wai_release: assert property (s_wai_taken ##1 !ops_busy && !test_busy |=> cmd_ready)
        else $error("Wait did not release");
    a_cond_trips: assert property (1'b1 |=> fault_condition[0] == $past(high_voltage_trip)
        && fault_condition[1] == $past(excess_current_trip)
        && fault_condition[4] == $past(thermal_trip))
        else $error("Trip bits misplaced");
    a_cond_ceilings: assert property (1'b1 |=> fault_condition[8] == $past(voltage_ceiling_hit)
        && fault_condition[9] == $past(current_ceiling_hit)
        && fault_condition[12] == $past(power_ceiling_hit))
        else $error("Ceiling bits misplaced");
    a_cond_others: assert property (1'b1 |=> fault_condition[3] == $past(mains_switch_off)
        && fault_condition[5] == $past(thermocouple_short)
        && fault_condition[6] == $past(temperature_threshold)
        && fault_condition[11] == $past(shutdown_alarm)
        && fault_condition[13] == $past(sense_alarm)
        && (fault_condition & ~FLT_USED) == 16'h0000)
        else $error("Other fault bits misplaced");
    a_cond_read: assert property (take && cmd_code == CMD_COND_GET
        |=> rsp_data == $past(fault_condition))
        else $error("Condition read wrong");
    a_rise_catch: assert property (fault_condition[0] && !$past(fault_condition[0])
        && fault_rise_filter[0] |=> fault_event_latch[0])
        else $error("Rising change not latched");
    a_fall_catch: assert property (!fault_condition[1] && $past(fault_condition[1])
        && fault_fall_filter[1] |=> fault_event_latch[1])
        else $error("Falling change not latched");
    a_evt_clear: assert property (evt_clear
        |=> rsp_data == $past(fault_event_latch) && fault_event_latch == $past(evt_set))
        else $error("Event read did not clear");
    a_summary_or: assert property (1'b1
        |=> fault_summary == |($past(fault_event_latch) & $past(fault_enable_mask))
        && status_byte[3] == fault_summary)
        else $error("Fault summary wrong");
    a_mask_write: assert property (take && cmd_code == CMD_ENA_SET
        |=> fault_enable_mask == $past(cmd_data))
        else $error("Enable mask not stored");
    // Mask taken one cycle back, as the request flop saw it during a mask write
    a_srq_raise: assert property (1'b1 |=> service_request == status_byte[6]
        && service_request == |(status_byte & $past(service_request_mask) & 8'hBF))
        else $error("Service request wrong");
    a_srq_gate: assert property (1'b1
        |=> !service_request || (|($past(service_request_mask) & 8'hBF)))
        else $error("Request without enabled bit");
    a_sre_readback: assert property (take && cmd_code == CMD_SRE_GET
        |=> rsp_valid && rsp_data == {8'h00, $past(service_request_mask)})
        else $error("Request mask read wrong");
    a_stb_passthru: assert property (1'b1
        |=> (status_byte & 8'hB7) == ($past(stb_external) & 8'hB7))
        else $error("Status byte sources wrong");
    a_trg_quiet: assert property (!(take && cmd_code == CMD_TRG)
        |=> !trig_pulse && !err_valid)
        else $error("Trigger output without command");
    // Busy phases must hold off the host
    a_state_refuse: assert property (state != ST_IDLE
        |-> !cmd_ready)
        else $error("Command ready while busy");
    a_tst_refuse: assert property (test_busy
        |-> !cmd_ready)
        else $error("Command ready during self test");
    a_cond_unchanged: assert property (take && cmd_code == CMD_COND_GET
        |=> rsp_valid && fault_condition == $past(next_condition))
        else $error("Condition disturbed by read");
    a_set_silent: assert property (take && cmd_code inside {CMD_SRE_SET, CMD_RISE_SET,
        CMD_FALL_SET, CMD_ENA_SET, CMD_TRG, CMD_WAI} |=> !rsp_valid)
        else $error("Answer given to a set command");
endmodule : srsr_top

// ---- verification/srsr_host.sv ----
// Remote host model driving the command port of the status reporting block
`timescale 1ns/10ps
module srsr_host
    import srsr_pkg::*;
(
    input wire logic clk,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    output logic cmd_valid,
    output srsr_pkg::srsr_cmd_type cmd_code,
    output logic [15:0] cmd_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = CMD_SRE_GET;
        cmd_data = 16'h0000;
    end

    // Request held until seen taken or for at most 64 cycles; data inverted on release so stale values never match
    task automatic issue(input srsr_cmd_type code, input logic [15:0] data,
                         input bit want_rsp, output logic [15:0] rsp, output bit ok);
        int n;
        ok = 1'b0;
        rsp = 16'h0000;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_data <= data;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (cmd_ready === 1'b1) break;
        end
        cmd_valid <= 1'b0;
        cmd_data <= ~data;
        if (n == 64) return;
        if (!want_rsp) begin
            ok = 1'b1;
            return;
        end
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (rsp_valid === 1'b1) begin
                rsp = rsp_data;
                ok = 1'b1;
                return;
            end
        end
    endtask : issue
endmodule : srsr_host

// ---- verification/srsr_top_test.sv ----
// Self-checking bench for the status reporting block
`timescale 1ns/10ps
module srsr_top_test;
    import srsr_pkg::*;
    logic clk;
    logic sys_rst;
    logic cmd_valid;
    srsr_cmd_type cmd_code;
    logic [15:0] cmd_data, rsp_data, err_code, cond_vec, self_test_fault;
    logic cmd_ready, rsp_valid, err_valid, trig_pulse, service_request, fault_summary;
    logic [7:0] stb_external, status_byte;
    logic trig_accept_ok, ops_busy;
    int failures, comparisons;
    int pos [11] = '{0, 1, 3, 4, 5, 6, 8, 9, 11, 12, 13};
    logic [15:0] pat;
    logic tp, ev;

    always #4 clk = ~clk;

    // Short self test keeps the run brief
    srsr_top #(.TEST_CYCLES(2)) DUT (
        .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .err_valid(err_valid), .err_code(err_code),
        .high_voltage_trip(cond_vec[0]), .excess_current_trip(cond_vec[1]),
        .mains_switch_off(cond_vec[3]), .thermal_trip(cond_vec[4]),
        .thermocouple_short(cond_vec[5]), .temperature_threshold(cond_vec[6]),
        .voltage_ceiling_hit(cond_vec[8]), .current_ceiling_hit(cond_vec[9]),
        .shutdown_alarm(cond_vec[11]), .power_ceiling_hit(cond_vec[12]),
        .sense_alarm(cond_vec[13]), .stb_external(stb_external),
        .trig_accept_ok(trig_accept_ok), .ops_busy(ops_busy),
        .self_test_fault(self_test_fault), .trig_pulse(trig_pulse),
        .service_request(service_request), .status_byte(status_byte),
        .fault_summary(fault_summary)
    );

    srsr_host u_host (
        .clk(clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data)
    );

    task automatic stop_test();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cmd(input srsr_cmd_type code, input logic [15:0] data, input bit want,
                       output logic [15:0] rsp);
        bit ok;
        u_host.issue(code, data, want, rsp, ok);
        if (!ok) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, 16'h0000, 16'h0001);
            stop_test();
        end
    endtask : cmd

    task automatic get(input srsr_cmd_type code, input logic [15:0] exp);
        logic [15:0] r;
        cmd(code, 16'h0000, 1'b1, r);
        check(r, exp);
    endtask : get

    task automatic put(input srsr_cmd_type code, input logic [15:0] data);
        logic [15:0] r;
        cmd(code, data, 1'b0, r);
    endtask : put

    // Condition to summary path is three registered stages
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        cond_vec = 16'h0000;
        stb_external = 8'h00;
        trig_accept_ok = 1'b1;
        ops_busy = 1'b0;
        self_test_fault = 16'h0000;
        failures = 0;
        comparisons = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        get(CMD_SRE_GET, 16'h0000);
        get(CMD_RISE_GET, 16'h3B7B);
        get(CMD_FALL_GET, 16'h0000);
        get(CMD_ENA_GET, 16'h0000);
        get(CMD_EVT_GET, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            pat = (i == 0) ? 16'h5AC3 : 16'hFFFF;
            put(CMD_SRE_SET, pat);
            get(CMD_SRE_GET, {8'h00, pat[7:0]});
            put(CMD_RISE_SET, pat);
            get(CMD_RISE_GET, pat);
            put(CMD_FALL_SET, ~pat);
            get(CMD_FALL_GET, ~pat);
            put(CMD_ENA_SET, pat);
            get(CMD_ENA_GET, pat);
        end
        put(CMD_ENA_SET, 16'h0000);
        put(CMD_SRE_SET, 16'h0000);
        get(CMD_EVT_GET, 16'h0000);
        // Walk one live condition at a time, rising edges only
        for (int i = 0; i < 11; i++) begin
            cond_vec <= 16'h0001 << pos[i];
            settle();
            get(CMD_COND_GET, 16'h0001 << pos[i]);
            get(CMD_COND_GET, 16'h0001 << pos[i]);
            get(CMD_EVT_GET, 16'h0001 << pos[i]);
        end
        cond_vec <= 16'h0000;
        settle();
        get(CMD_EVT_GET, 16'h0000);
        put(CMD_RISE_SET, 16'h0000);
        put(CMD_FALL_SET, 16'h0002);
        cond_vec <= 16'h0002;
        settle();
        get(CMD_EVT_GET, 16'h0000);
        cond_vec <= 16'h0000;
        settle();
        check({15'h0000, fault_summary}, 16'h0000);
        put(CMD_ENA_SET, 16'h0002);
        settle();
        check({15'h0000, fault_summary}, 16'h0001);
        check({15'h0000, service_request}, 16'h0000);
        put(CMD_SRE_SET, 16'h0008);
        settle();
        check({15'h0000, service_request}, 16'h0001);
        check({8'h00, status_byte}, 16'h0048);
        get(CMD_STB_GET, 16'h0048);
        get(CMD_EVT_GET, 16'h0002);
        stb_external <= 8'h10;
        settle();
        check({14'h0000, fault_summary, service_request}, 16'h0000);
        get(CMD_STB_GET, 16'h0010);
        for (int t = 0; t < 2; t++) begin
            trig_accept_ok <= t[0];
            put(CMD_TRG, 16'h0000);
            tp = 1'b0;
            ev = 1'b0;
            repeat (4) begin
                @(posedge clk);
                tp = tp | (trig_pulse === 1'b1);
                ev = ev | (err_valid === 1'b1);
            end
            check({14'h0000, tp, ev}, (t == 1) ? 16'h0002 : 16'h0001);
            if (t == 0) check(err_code, 16'hFF2D);
        end
        for (int t = 0; t < 2; t++) begin
            self_test_fault <= (t == 1) ? 16'h0042 : 16'h0000;
            get(CMD_TST, (t == 1) ? 16'h0042 : 16'h0000);
        end
        ops_busy <= 1'b1;
        put(CMD_WAI, 16'h0000);
        repeat (8) @(posedge clk);
        check({15'h0000, cmd_ready}, 16'h0000);
        ops_busy <= 1'b0;
        get(CMD_SRE_GET, 16'h0008);
        stop_test();
    end
endmodule : srsr_top_test
